// ===== src/irq_wake_pkg.sv
// Constants and types for the interrupt option and low-power wake block
package irq_wake_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_INTERRUPT_OPTION = 32'h0000_00c8;
	localparam logic [31:0] ADDR_SOURCE_ENABLE = 32'h0000_00e0;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_00e4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] INTERRUPT_OPTION_RESET = 8'h00;
	localparam logic [4:0] SOURCE_ENABLE_RESET = 5'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int LEVEL_EDGE_SELECT_BIT = 6;
	localparam int EDGE_POLARITY_SELECT_BIT = 5;
	localparam int GLOBAL_IRQ_ENABLE_BIT = 4;
	localparam int TIMER_IRQ_ENABLE_BIT = 0;
	localparam int ADC_IRQ_ENABLE_BIT = 1;
	localparam int OSC_IRQ_ENABLE_BIT = 2;
	localparam int SUPERVISOR_IRQ_ENABLE_BIT = 3;
	localparam int OSC_SELECT_BIT = 4;
	localparam int STATUS_REQUEST_LSB = 0;
	localparam int STATUS_MODE_LSB = 8;
	localparam int STATUS_POWER_LSB = 12;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int STAB_TIME_NS = 102400;
	localparam logic [15:0] STAB_CYCLES = 16'((STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// Vectors, modes and power states
	// ------------------------------------------------------------
	localparam logic [2:0] VECTOR_NMI = 3'h0;
	localparam logic [2:0] VECTOR_NONE = 3'h7;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_IRQ,
		MODE_NMI
	} core_mode_t;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_WAIT,
		PWR_STOP,
		PWR_STABILISE
	} power_state_t;

endpackage

// ===== src/interrupt_option_and_low_power_wake.sv
// Interrupt option register, source arbitration and WAIT/STOP wake control
`timescale 1ns/1ps
// Behaviour
// - Option register at 0C8h is write-only; reads return zero.
// - Option register clears to 00h on reset.
// - Bit 7 and bits 3-0 of the option register are ignored.
// - Level_edge_select high makes source 1 level sensitive, low edge sensitive.
// - Edge_polarity_select chooses the edge polarity of source 2.
// - Polarity set means rising, cleared falling; source 1 edge mode is falling.
// - Global_irq_enable gates all maskable sources; non-maskable stays serviceable.
// - With global_irq_enable low nothing wakes the core from WAIT or STOP.
// - Timer and oscillator events request source 3; converter requests source 4.
// - Serial end requests source 1, port pins source 2, supervisor source 0.
// - Non-maskable pre-empts all; maskable never nest; fixed order 1 to 4.
// - Edge latches keep one edge until routine start; level sources unstored.
// - Return from interrupt restores the previous flag set and pops the PC.
// - WAIT halts execution with oscillator and peripherals running.
// - Leaving WAIT by interrupt adds no stabilisation delay.
// - STOP halts the oscillator; only external interrupt or reset ends it.
// - Leaving STOP by interrupt waits the stabilisation delay first.
// - Reset during WAIT or STOP follows the normal reset path.
// - Low-power from main routine: waking interrupt is serviced, then execution continues.
// - Low-power inside non-maskable routine: any interrupt resumes it, nothing serviced.
// - Inside maskable routine, maskable wake resumes it; pending served after return.
// - Inside maskable routine, non-maskable wake is serviced first, then resume.
// - With watchdog active a STOP is performed as a WAIT.
// - WAIT and STOP are ignored while an enabled request is pending.
// - Interrupt entry and return never change the oscillator selection.
module interrupt_option_and_low_power_wake #(
	parameter int port_pins = 24,
	parameter logic [15:0] stab_cycles = irq_wake_pkg::STAB_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic instr_done,
	input wire logic wait_cmd,
	input wire logic stop_cmd,
	input wire logic return_from_irq,
	input wire logic watchdog_active,
	input wire logic [1:0] timer_zero_flag,
	input wire logic osc_count_done_flag,
	input wire logic adc_eoc,
	input wire logic serial_eot_n,
	input wire logic [port_pins-1:0] port_pin,
	input wire logic [port_pins-1:0] port_irq_sel,
	input wire logic supply_supervisor,
	output logic irq_take,
	output logic [2:0] irq_vector,
	output logic pc_pop,
	output logic [1:0] flag_set,
	output logic core_halt,
	output logic osc_run,
	output logic osc_select,
	output logic resume,
	output logic supervisor_irq_flag
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic level_edge_select;
		logic edge_polarity_select;
		logic gen;
		logic [4:0] src_en;
		logic wr_pend;
		logic [31:0] wr_addr;
		logic [31:0] rdata;
		logic line1_q;
		logic line2_q;
		logic sup_q;
		logic lat0;
		logic lat1;
		logic lat2;
		irq_wake_pkg::core_mode_t mode;
		irq_wake_pkg::core_mode_t nmi_prev;
		irq_wake_pkg::power_state_t pstate;
		logic [15:0] stab_cnt;
		logic take;
		logic [2:0] vector;
		logic pop;
		logic resume;
	} state_t;

	state_t s;
	state_t next_s;

	// Highest-priority maskable source, 1 first
	function automatic logic [2:0] pick_source(input logic [4:1] r);
		logic [2:0] v;
		v = irq_wake_pkg::VECTOR_NONE;
		if (r[1]) begin
			v = 3'h1;
		end else if (r[2]) begin
			v = 3'h2;
		end else if (r[3]) begin
			v = 3'h3;
		end else if (r[4]) begin
			v = 3'h4;
		end
		return v;
	endfunction

	// Register select from a byte address; shared by the write and read paths
	function automatic logic [1:0] reg_select(input logic [31:0] a);
		logic [1:0] sel;
		sel = 2'h0;
		if (a == irq_wake_pkg::ADDR_INTERRUPT_OPTION) begin
			sel = 2'h1;
		end else if (a == irq_wake_pkg::ADDR_SOURCE_ENABLE) begin
			sel = 2'h2;
		end else if (a == irq_wake_pkg::ADDR_STATUS) begin
			sel = 2'h3;
		end
		return sel;
	endfunction

	// Edge of the wanted polarity between last and present sample
	function automatic logic edge_seen(input logic prev, input logic now, input logic rising);
		logic hit;
		hit = rising ? (!prev && now) : (prev && !now);
		return hit;
	endfunction

	// ------------------------------------------------------------
	// Request lines
	// ------------------------------------------------------------
	logic line2;
	logic sup_ev;
	logic [4:0] req;
	logic [4:1] mreq;
	logic pending_any;
	logic ext_wake;
	logic can_sample;
	logic [2:0] best;

	// Any selected pin pulled low drives the shared line low
	assign line2 = &(port_pin | ~port_irq_sel);
	assign sup_ev = supply_supervisor & s.src_en[irq_wake_pkg::SUPERVISOR_IRQ_ENABLE_BIT];
	assign req[0] = s.lat0;
	assign req[1] = s.level_edge_select ? ~serial_eot_n : s.lat1;
	assign req[2] = s.lat2;
	assign req[3] = (s.src_en[irq_wake_pkg::TIMER_IRQ_ENABLE_BIT] & (|timer_zero_flag))
		| (s.src_en[irq_wake_pkg::OSC_IRQ_ENABLE_BIT] & osc_count_done_flag);
	assign req[4] = s.src_en[irq_wake_pkg::ADC_IRQ_ENABLE_BIT] & adc_eoc;
	assign mreq = req[4:1] & {4{s.gen}};
	assign pending_any = req[0] | (|mreq);
	// Oscillator is dead in STOP, so only the supervisor (source 0) and port pin (source 2) sources can end it
	assign ext_wake = req[0] | (s.gen & req[2]);
	assign can_sample = (s.pstate == irq_wake_pkg::PWR_RUN) & (instr_done | s.resume);
	assign best = pick_source(mreq);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.take = 1'b0;
		next_s.pop = 1'b0;
		next_s.resume = 1'b0;
		next_s.wr_pend = 1'b0;
		next_s.rdata = 32'h0000_0000;

		// Bus data phase: write lands here
		if (s.wr_pend) begin
			if (reg_select(s.wr_addr) == 2'h1) begin
				// Unused bits simply have no flop
				next_s.level_edge_select = hwdata[irq_wake_pkg::LEVEL_EDGE_SELECT_BIT];
				next_s.edge_polarity_select = hwdata[irq_wake_pkg::EDGE_POLARITY_SELECT_BIT];
				next_s.gen = hwdata[irq_wake_pkg::GLOBAL_IRQ_ENABLE_BIT];
			end else if (reg_select(s.wr_addr) == 2'h2) begin
				next_s.src_en = hwdata[4:0];
			end
		end

		// ------------------------------------------------------------
		// Bus address phase
		// ------------------------------------------------------------
		if (hsel && hready && htrans[1]) begin
			next_s.wr_pend = hwrite;
			next_s.wr_addr = haddr;
			if (!hwrite) begin
				if (reg_select(haddr) == 2'h1) begin
					next_s.rdata = 32'h0000_0000;
				end else if (reg_select(haddr) == 2'h2) begin
					next_s.rdata = {27'h000_0000, s.src_en};
				end else if (reg_select(haddr) == 2'h3) begin
					next_s.rdata = {18'h0_0000, s.pstate, 2'h0, s.mode, 3'h0, req};
				end
			end
		end

		next_s.line1_q = serial_eot_n;
		next_s.line2_q = line2;
		next_s.sup_q = sup_ev;

		// ------------------------------------------------------------
		// Arbitration at instruction boundaries and on wake
		// ------------------------------------------------------------
		if (can_sample && req[0] && s.mode != irq_wake_pkg::MODE_NMI) begin
			next_s.take = 1'b1;
			next_s.vector = irq_wake_pkg::VECTOR_NMI;
			next_s.nmi_prev = s.mode;
			next_s.mode = irq_wake_pkg::MODE_NMI;
			next_s.lat0 = 1'b0;
		end else if (can_sample && s.mode == irq_wake_pkg::MODE_NORMAL && (|mreq)) begin
			next_s.take = 1'b1;
			next_s.vector = best;
			next_s.mode = irq_wake_pkg::MODE_IRQ;
			if (best == 3'h1) begin
				next_s.lat1 = 1'b0;
			end
			if (best == 3'h2) begin
				next_s.lat2 = 1'b0;
			end
		end else if (return_from_irq && s.pstate == irq_wake_pkg::PWR_RUN && s.mode != irq_wake_pkg::MODE_NORMAL) begin
			next_s.pop = 1'b1;
			if (s.mode == irq_wake_pkg::MODE_NMI) begin
				next_s.mode = s.nmi_prev;
			end else begin
				next_s.mode = irq_wake_pkg::MODE_NORMAL;
			end
		end

		// ------------------------------------------------------------
		// Power sequencing
		// ------------------------------------------------------------
		case (s.pstate)
			irq_wake_pkg::PWR_RUN: begin
				if (!next_s.take && !pending_any) begin
					if (stop_cmd && !watchdog_active) begin
						next_s.pstate = irq_wake_pkg::PWR_STOP;
					end else if (wait_cmd || stop_cmd) begin
						next_s.pstate = irq_wake_pkg::PWR_WAIT;
					end
				end
			end
			irq_wake_pkg::PWR_WAIT: begin
				if (s.gen && pending_any) begin
					next_s.pstate = irq_wake_pkg::PWR_RUN;
					next_s.resume = 1'b1;
				end
			end
			irq_wake_pkg::PWR_STOP: begin
				if (s.gen && ext_wake) begin
					next_s.pstate = irq_wake_pkg::PWR_STABILISE;
					next_s.stab_cnt = stab_cycles - 16'h0001;
				end
			end
			default: begin
				if (s.stab_cnt == 16'h0000) begin
					next_s.pstate = irq_wake_pkg::PWR_RUN;
					next_s.resume = 1'b1;
				end else begin
					next_s.stab_cnt = s.stab_cnt - 16'h0001;
				end
			end
		endcase

		// ------------------------------------------------------------
		// Edge capture last, so a new edge beats a same-cycle clear
		// ------------------------------------------------------------
		if (!s.level_edge_select && edge_seen(s.line1_q, serial_eot_n, 1'b0)) begin
			next_s.lat1 = 1'b1;
		end
		if (edge_seen(s.line2_q, line2, s.edge_polarity_select)) begin
			next_s.lat2 = 1'b1;
		end
		if (edge_seen(s.sup_q, sup_ev, 1'b1)) begin
			next_s.lat0 = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Reset wins from any power state
			s <= '0;
			s.level_edge_select <= irq_wake_pkg::INTERRUPT_OPTION_RESET[irq_wake_pkg::LEVEL_EDGE_SELECT_BIT];
			s.edge_polarity_select <= irq_wake_pkg::INTERRUPT_OPTION_RESET[irq_wake_pkg::EDGE_POLARITY_SELECT_BIT];
			s.gen <= irq_wake_pkg::INTERRUPT_OPTION_RESET[irq_wake_pkg::GLOBAL_IRQ_ENABLE_BIT];
			s.src_en <= irq_wake_pkg::SOURCE_ENABLE_RESET;
			s.line1_q <= 1'b1;
			s.line2_q <= 1'b1;
			s.mode <= irq_wake_pkg::MODE_NORMAL;
			s.nmi_prev <= irq_wake_pkg::MODE_NORMAL;
			s.pstate <= irq_wake_pkg::PWR_RUN;
			s.vector <= irq_wake_pkg::VECTOR_NONE;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign irq_take = s.take;
	assign irq_vector = s.vector;
	assign pc_pop = s.pop;
	assign flag_set = s.mode;
	assign core_halt = (s.pstate != irq_wake_pkg::PWR_RUN);
	assign osc_run = (s.pstate != irq_wake_pkg::PWR_STOP);
	// Only software writes touch this bit
	assign osc_select = s.src_en[irq_wake_pkg::OSC_SELECT_BIT];
	assign resume = s.resume;
	assign supervisor_irq_flag = s.lat0;

endmodule

// ===== verif/irq_wake_props.sv
// Checker for the option register and wake control ports
`timescale 1ns/1ps
module irq_wake_props #(
	parameter logic [15:0] stab_cycles = 16'h0004
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic wait_cmd,
	input wire logic stop_cmd,
	input wire logic return_from_irq,
	input wire logic watchdog_active,
	input wire logic irq_take,
	input wire logic [2:0] irq_vector,
	input wire logic pc_pop,
	input wire logic [1:0] flag_set,
	input wire logic core_halt,
	input wire logic osc_run,
	input wire logic osc_select,
	input wire logic resume
);
	// Slack of one edge below and two above, the stabilise count start is registered
	localparam int stab_lo = stab_cycles - 1;
	localparam int stab_hi = stab_cycles + 2;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence opt_read_s;
		hsel && hready && htrans[1] && !hwrite && haddr == irq_wake_pkg::ADDR_INTERRUPT_OPTION;
	endsequence
	sequence stop_wake_s;
		$rose(osc_run) && core_halt;
	endsequence
	opt_read_zero_a: assert property (opt_read_s |=> hrdata == 32'h0000_0000)
		else $error("option register read not zero");
	halt_cause_a: assert property ($rose(core_halt) |-> $past(wait_cmd || stop_cmd))
		else $error("halt without wait or stop");
	stop_osc_a: assert property ($fell(osc_run) |-> $past(stop_cmd && !watchdog_active))
		else $error("oscillator stopped without plain stop");
	stop_halt_a: assert property (!osc_run |-> core_halt)
		else $error("oscillator off while running");
	wake_resume_a: assert property (resume |-> !core_halt && $past(core_halt))
		else $error("resume not at end of halt");
	stab_delay_a: assert property (stop_wake_s |-> ##[stab_lo:stab_hi] resume)
		else $error("stabilise delay wrong");
	mask_nest_a: assert property (irq_take && irq_vector != irq_wake_pkg::VECTOR_NMI |-> $past(flag_set) == irq_wake_pkg::MODE_NORMAL)
		else $error("maskable entry outside normal mode");
	nmi_mode_a: assert property (irq_take && irq_vector == irq_wake_pkg::VECTOR_NMI |-> flag_set == irq_wake_pkg::MODE_NMI)
		else $error("non-maskable entry mode wrong");
	irq_return_a: assert property (return_from_irq && !core_halt && flag_set == irq_wake_pkg::MODE_IRQ
		|=> pc_pop && flag_set == irq_wake_pkg::MODE_NORMAL)
		else $error("return did not restore normal mode");
	osc_keep_a: assert property (irq_take || pc_pop |-> $stable(osc_select))
		else $error("oscillator selection moved");
endmodule
bind interrupt_option_and_low_power_wake irq_wake_props #(.stab_cycles(stab_cycles)) u_irq_wake_props (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .wait_cmd, .stop_cmd, .return_from_irq,
	.watchdog_active, .irq_take, .irq_vector, .pc_pop, .flag_set, .core_halt, .osc_run, .osc_select, .resume);

// ===== verif/irq_core_model.sv
// Core sequencer model: instruction ends and routine returns
`timescale 1ns/1ps
module irq_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic core_halt,
	input wire logic irq_take,
	output logic instr_done,
	output logic return_from_irq
);
	logic [3:0] busy;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_done <= 1'h0;
			return_from_irq <= 1'h0;
			busy <= 4'h0;
		end else begin
			// No instruction ends while halted, so a routine stalls in WAIT or STOP
			instr_done <= !core_halt && !instr_done;
			return_from_irq <= busy == 4'h1 && !core_halt;
			if (irq_take)
				busy <= 4'h8;
			else if (busy != 4'h0 && !core_halt)
				busy <= busy - 4'h1;
		end
	end
endmodule

// ===== verif/interrupt_option_and_low_power_wake_tb_top.sv
// Self-checking bench for the option and wake block
`timescale 1ns/1ps
module interrupt_option_and_low_power_wake_tb_top;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, wait_cmd = 1'h0, stop_cmd = 1'h0;
	logic watchdog_active = 1'h0, osc_count_done_flag = 1'h0, adc_eoc = 1'h0, serial_eot_n = 1'h1;
	logic supply_supervisor = 1'h0, hreadyout, hresp, instr_done, return_from_irq, irq_take, pc_pop;
	logic core_halt, osc_run, osc_select, resume, supervisor_irq_flag;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
	logic [1:0] htrans = 2'h0, timer_zero_flag = 2'h0, flag_set;
	logic [23:0] port_pin = 24'hff_ffff, port_irq_sel = 24'h00_0000;
	logic [2:0] irq_vector;
	int fails = 0, samples_checked = 0;
	interrupt_option_and_low_power_wake #(.stab_cycles(16'h0004)) u_interrupt_option_and_low_power_wake (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .instr_done, .wait_cmd, .stop_cmd, .return_from_irq, .watchdog_active, .timer_zero_flag,
		.osc_count_done_flag, .adc_eoc, .serial_eot_n, .port_pin, .port_irq_sel, .supply_supervisor, .irq_take,
		.irq_vector, .pc_pop, .flag_set, .core_halt, .osc_run, .osc_select, .resume, .supervisor_irq_flag);
	irq_core_model u_irq_core_model (.hclk, .hresetn, .core_halt, .irq_take, .instr_done, .return_from_irq);
	initial begin
		forever #25 hclk = ~hclk;
	end
	task automatic end_sim;
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic take(input logic [2:0] e);
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (irq_take !== 1'h1 && i < 60);
		check("take", {irq_take, irq_vector}, {1'h1, e});
	endtask
	task automatic quiet(input int n);
		int i, seen;
		seen = 0;
		for (i = 0; i < n; i++) begin
			@(posedge hclk);
			if (irq_take !== 1'h0)
				seen++;
		end
		check("no take", seen, 0);
	endtask
	task automatic cmd(input logic s);
		@(posedge hclk);
		wait_cmd <= !s;
		stop_cmd <= s;
		@(posedge hclk);
		wait_cmd <= 1'h0;
		stop_cmd <= 1'h0;
		@(posedge hclk);
	endtask
	task automatic pin_rise;
		port_pin[0] <= 1'h0;
		repeat (2) @(posedge hclk);
		port_pin[0] <= 1'h1;
	endtask
	task automatic s_reset;
		check("irq_vector", irq_vector, 3'h7);
		check("flag_set", flag_set, 2'h0);
		check("reset outs", {hresp, osc_select, supervisor_irq_flag, resume, pc_pop, core_halt, osc_run}, 7'h01);
		bus(1'h0, irq_wake_pkg::ADDR_INTERRUPT_OPTION, 32'h0000_0000);
		check("option read", rd, 32'h0000_0000);
		bus(1'h0, 32'h0000_0100, 32'h0000_0000);
		check("unmapped read", rd, 32'h0000_0000);
	endtask
	task automatic s_mask;
		bus(1'h1, irq_wake_pkg::ADDR_SOURCE_ENABLE, 32'h0000_001f);
		bus(1'h0, irq_wake_pkg::ADDR_SOURCE_ENABLE, 32'h0000_0000);
		check("enable read", rd, 32'h0000_001f);
		bus(1'h1, irq_wake_pkg::ADDR_INTERRUPT_OPTION, 32'h0000_008f);
		adc_eoc <= 1'h1;
		quiet(20);
		supply_supervisor <= 1'h1;
		repeat (2) @(posedge hclk);
		check("supervisor flag", supervisor_irq_flag, 1'h1);
		take(3'h0);
		supply_supervisor <= 1'h0;
		bus(1'h1, irq_wake_pkg::ADDR_INTERRUPT_OPTION, 32'h0000_0010);
		take(3'h4);
		adc_eoc <= 1'h0;
	endtask
	task automatic s_prio;
		osc_count_done_flag <= 1'h1;
		adc_eoc <= 1'h1;
		serial_eot_n <= 1'h0;
		take(3'h1);
		serial_eot_n <= 1'h1;
		take(3'h3);
		osc_count_done_flag <= 1'h0;
		take(3'h4);
		adc_eoc <= 1'h0;
		check("osc select kept", osc_select, 1'h1);
	endtask
	task automatic s_level;
		bus(1'h1, irq_wake_pkg::ADDR_INTERRUPT_OPTION, 32'h0000_0070);
		serial_eot_n <= 1'h0;
		take(3'h1);
		serial_eot_n <= 1'h1;
		port_irq_sel <= 24'h00_0001;
		port_pin[0] <= 1'h0;
		quiet(12);
		port_pin[0] <= 1'h1;
		take(3'h2);
	endtask
	task automatic s_wait;
		cmd(1'h0);
		check("halt in wait", core_halt, 1'h1);
		check("osc in wait", osc_run, 1'h1);
		timer_zero_flag <= 2'h1;
		repeat (2) @(posedge hclk);
		check("resume", resume, 1'h1);
		take(3'h3);
		cmd(1'h0);
		check("wait with pending", core_halt, 1'h0);
		timer_zero_flag <= 2'h0;
	endtask
	task automatic s_stop;
		watchdog_active <= 1'h1;
		cmd(1'h1);
		check("stop as wait osc", osc_run, 1'h1);
		check("stop as wait halt", core_halt, 1'h1);
		adc_eoc <= 1'h1;
		take(3'h4);
		adc_eoc <= 1'h0;
		watchdog_active <= 1'h0;
		cmd(1'h1);
		check("osc in stop", osc_run, 1'h0);
		adc_eoc <= 1'h1;
		quiet(10);
		adc_eoc <= 1'h0;
		pin_rise;
		take(3'h2);
	endtask
	task automatic s_gen0;
		bus(1'h1, irq_wake_pkg::ADDR_INTERRUPT_OPTION, 32'h0000_0020);
		cmd(1'h0);
		pin_rise;
		quiet(10);
		check("halt kept", core_halt, 1'h1);
		bus(1'h0, irq_wake_pkg::ADDR_STATUS, 32'h0000_0000);
		check("status", rd, 32'h0000_1104);
		hresetn <= 1'h0;
		@(posedge hclk);
		check("reset in wait", core_halt, 1'h0);
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		s_reset;
		s_mask;
		s_prio;
		s_level;
		s_wait;
		s_stop;
		s_gen0;
		end_sim;
	end
	// Whole run needs well under two thousand cycles
	initial begin
		repeat (5000) @(posedge hclk);
		fails++;
		end_sim;
	end
endmodule
